// file: hw/oscillator_spread_spectrum_ctrl.sv
// spread spectrum sweep of the internal oscillator control value
`timescale 1ns/100ps
module oscillator_spread_spectrum_ctrl
    import spread_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic regWrite,
    input wire logic [spread_pkg::DATA_W-1:0] regAddr,
    input wire logic [spread_pkg::DATA_W-1:0] regWdata,
    output logic [spread_pkg::DATA_W-1:0] regRdata,
    // oscillator control
    input wire logic [spread_pkg::OSC_W-1:0] oscCtrlBase,
    output logic [spread_pkg::OSC_W-1:0] oscCtrlOut,
    output logic spreadActive
);
    logic [DATA_W-1:0] configQ;
    logic [DATA_W-1:0] readQ;

    spread_config_reg u_cfg (
        .mclk(mclk),
        .rst_n(rst_n),
        .regWrite(regWrite),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .configQ(configQ),
        .readQ(readQ)
    );

    wire [3:0] sweepRateField = configQ[RATE_HI:RATE_LO];
    wire [1:0] sweepAmplitudeField = configQ[AMP_HI:AMP_LO];
    wire spreadOn = sweepRateField != RATE_OFF;

    // amplitude decode
    wire [OFS_W-1:0] ampLimit = (sweepAmplitudeField == 2'b00) ? AMP_4 :
                                (sweepAmplitudeField == 2'b01) ? AMP_8 :
                                (sweepAmplitudeField == 2'b10) ? AMP_16 : AMP_32;

    // pace counter: step period = rate * PACE_UNIT cycles
    logic [PACE_W+3:0] pace_reg;
    wire [PACE_W+3:0] paceLimit = 12'(sweepRateField * PACE_UNIT);
    wire paceTick = spreadOn && (pace_reg >= paceLimit - 12'h001);
    wire [PACE_W+3:0] pace_next = (!spreadOn || paceTick) ? PACE_ZERO : pace_reg + 12'h001;

    // triangle offset, signed
    logic signed [OFS_W:0] offset_reg;
    sweep_dir_t dir_reg;
    wire signed [OFS_W:0] posLim = $signed({1'b0, ampLimit});
    wire signed [OFS_W:0] negLim = -posLim;
    wire atTop = offset_reg >= posLim;
    wire atBot = offset_reg <= negLim;
    sweep_dir_t dir_next;
    logic signed [OFS_W:0] offset_next;

    always_comb begin
        dir_next = dir_reg;
        offset_next = offset_reg;
        if (!spreadOn) begin
            dir_next = SWEEP_UP;
            offset_next = '0;
        end else if (atTop && dir_reg == SWEEP_UP) begin
            dir_next = SWEEP_DOWN;
            offset_next = posLim;
        end else if (atBot && dir_reg == SWEEP_DOWN) begin
            dir_next = SWEEP_UP;
            offset_next = negLim;
        end else if (offset_reg > posLim) begin
            offset_next = posLim;
        end else if (offset_reg < negLim) begin
            offset_next = negLim;
        end else if (paceTick) begin
            case (dir_reg)
                SWEEP_UP: offset_next = offset_reg + 8'sd1;
                SWEEP_DOWN: offset_next = offset_reg - 8'sd1;
                default: offset_next = '0;
            endcase
        end
    end

    // base plus offset, saturated to the control range
    wire signed [OSC_W+1:0] sum = $signed({2'b00, oscCtrlBase}) + 10'(offset_reg);
    wire [OSC_W-1:0] oscNext = sum < 0 ? '0 : (sum > $signed({2'b00, OSC_MAX}) ? OSC_MAX : sum[OSC_W-1:0]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pace_reg <= PACE_ZERO;
            offset_reg <= '0;
            dir_reg <= SWEEP_UP;
            oscCtrlOut <= '0;
            spreadActive <= 1'b0;
        end else begin
            pace_reg <= pace_next;
            offset_reg <= offset_next;
            dir_reg <= dir_next;
            oscCtrlOut <= oscNext;
            spreadActive <= spreadOn;
        end
    end

    assign regRdata = readQ;

    // register access checks
    a_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
        regWrite && regAddr == CONFIG_OFFSET
        |=> configQ == ($past(regWdata) & CONFIG_MASK))
        else $error("config write did not land");

    a_write_miss: assert property (@(posedge mclk) disable iff (!rst_n)
        !(regWrite && regAddr == CONFIG_OFFSET)
        |=> $stable(configQ))
        else $error("config changed without a write");

    a_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(regAddr) == CONFIG_OFFSET
        |-> regRdata == configQ)
        else $error("read data differs from config");

    a_read_other: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(regAddr) != CONFIG_OFFSET
        |-> regRdata == '0)
        else $error("unmapped read not zero");

    a_read_low: assert property (@(posedge mclk) disable iff (!rst_n)
        regRdata[AMP_LO-1:0] == '0)
        else $error("low read bits not zero");

    // field decode checks
    a_rate_field: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadActive == $past(configQ[RATE_HI:RATE_LO] != RATE_OFF))
        else $error("rate field misread");

    a_active_rise: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(spreadActive)
        |-> $past(spreadOn) && $past(sweepRateField, 2) == RATE_OFF)
        else $error("active flag rose without rate write");

    a_amp_decode: assert property (@(posedge mclk) disable iff (!rst_n)
        ampLimit == OFS_W'(AMP_4 << sweepAmplitudeField))
        else $error("amplitude limit misdecoded");

    // sweep checks
    a_offset_range: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && $past(spreadOn) && $stable(ampLimit)
        |-> offset_reg <= posLim && offset_reg >= negLim)
        else $error("offset outside amplitude range");

    a_step_size: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && $past(spreadOn) && $stable(configQ) && configQ == $past(configQ, 2)
        |-> offset_reg - $past(offset_reg) <= 8'sd1 && $past(offset_reg) - offset_reg <= 8'sd1)
        else $error("offset moved by more than one step");

    a_step_pace: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(offset_reg) && spreadOn && $past(spreadOn) && $stable(configQ)
        |-> $past(paceTick) || atTop || atBot)
        else $error("offset stepped off pace");

    a_turn_top: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && offset_reg == posLim && dir_reg == SWEEP_UP
        |=> dir_reg == SWEEP_DOWN)
        else $error("sweep did not turn at top");

    a_turn_bot: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && offset_reg == negLim && dir_reg == SWEEP_DOWN
        |=> dir_reg == SWEEP_UP)
        else $error("sweep did not turn at bottom");

    a_dir_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && offset_reg < posLim && offset_reg > negLim
        |=> $stable(dir_reg))
        else $error("sweep turned inside range");

    a_pace_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && $stable(configQ)
        |-> pace_reg < paceLimit)
        else $error("pace counter beyond step period");

    a_pace_count: assert property (@(posedge mclk) disable iff (!rst_n)
        spreadOn && $stable(configQ) && !$past(paceTick)
        |-> pace_reg == $past(pace_reg) + 12'h001)
        else $error("pace counter skipped");

    a_pace_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(paceTick)
        |-> pace_reg == PACE_ZERO)
        else $error("pace counter not restarted");

    // spreading off checks
    a_rate_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !spreadOn
        |=> offset_reg == 0)
        else $error("offset not cleared when off");

    a_off_pace: assert property (@(posedge mclk) disable iff (!rst_n)
        !spreadOn
        |=> pace_reg == PACE_ZERO)
        else $error("pace counter running while off");

    a_off_dir: assert property (@(posedge mclk) disable iff (!rst_n)
        !spreadOn
        |=> dir_reg == SWEEP_UP)
        else $error("direction not reset while off");

    a_off_passthru: assert property (@(posedge mclk) disable iff (!rst_n)
        !spreadOn && $past(!spreadOn) && $stable(oscCtrlBase)
        |=> oscCtrlOut == $past(oscCtrlBase))
        else $error("output modulated while spreading off");

    // output checks
    a_sum_plain: assert property (@(posedge mclk) disable iff (!rst_n)
        oscCtrlBase >= 8'(AMP_32) && oscCtrlBase <= OSC_MAX - 8'(AMP_32)
        |=> $signed({2'b00, oscCtrlOut}) == $signed({2'b00, $past(oscCtrlBase)}) + $past(offset_reg))
        else $error("output is not base plus offset");

    a_sat_top: assert property (@(posedge mclk) disable iff (!rst_n)
        $signed({2'b00, oscCtrlBase}) + offset_reg > $signed({2'b00, OSC_MAX})
        |=> oscCtrlOut == OSC_MAX)
        else $error("output not held at top");

    a_sat_bottom: assert property (@(posedge mclk) disable iff (!rst_n)
        $signed({2'b00, oscCtrlBase}) + offset_reg < 0
        |=> oscCtrlOut == '0)
        else $error("output not held at bottom");
endmodule : oscillator_spread_spectrum_ctrl

// file: shared/spread_pkg.sv
// constants and types for the oscillator spread spectrum control
package spread_pkg;
    localparam int DATA_W = 8;
    localparam int OSC_W = 8;
    localparam int OFS_W = 7;
    localparam logic [DATA_W-1:0] CONFIG_OFFSET = 8'h76;
    localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
    localparam int RATE_HI = 7;
    localparam int RATE_LO = 4;
    localparam int AMP_HI = 3;
    localparam int AMP_LO = 2;
    localparam logic [3:0] RATE_OFF = 4'h0;
    localparam logic [1:0] AMP_RESET = 2'h0;
    localparam logic [DATA_W-1:0] CONFIG_MASK = 8'hfc;
    localparam int PACE_W = 8;
    // cycles per step = rate * PACE_UNIT
    localparam logic [PACE_W-1:0] PACE_UNIT = 8'h10;
    localparam logic [PACE_W+3:0] PACE_ZERO = 12'h000;
    localparam logic [OFS_W-1:0] AMP_4 = 7'h04;
    localparam logic [OFS_W-1:0] AMP_8 = 7'h08;
    localparam logic [OFS_W-1:0] AMP_16 = 7'h10;
    localparam logic [OFS_W-1:0] AMP_32 = 7'h20;
    localparam logic [OFS_W-1:0] OFS_ZERO = 7'h00;
    localparam logic [OSC_W-1:0] OSC_MAX = 8'hff;
    typedef enum logic {SWEEP_UP, SWEEP_DOWN} sweep_dir_t;
endpackage : spread_pkg

// file: hw/spread_config_reg.sv
// spread spectrum configuration register with registered read data
`timescale 1ns/100ps
module spread_config_reg
    import spread_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register access
    input wire logic regWrite,
    input wire logic [spread_pkg::DATA_W-1:0] regAddr,
    input wire logic [spread_pkg::DATA_W-1:0] regWdata,
    // contents
    output logic [spread_pkg::DATA_W-1:0] configQ,
    output logic [spread_pkg::DATA_W-1:0] readQ
);
    logic [DATA_W-1:0] config_reg;
    logic [DATA_W-1:0] read_reg;
    wire hit = regAddr == CONFIG_OFFSET;
    // low two bits are dropped so they read as zero
    wire [DATA_W-1:0] config_next = (regWrite && hit) ? (regWdata & CONFIG_MASK) : config_reg;
    wire [DATA_W-1:0] read_next = hit ? config_next : '0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= CONFIG_RESET;
            read_reg <= '0;
        end else begin
            config_reg <= config_next;
            read_reg <= read_next;
        end
    end

    assign configQ = config_reg;
    assign readQ = read_reg;

    a_low_bits_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        config_reg[AMP_LO-1:0] == '0)
        else $error("config low bits not zero");
endmodule : spread_config_reg

// file: dv/oscillator_spread_spectrum_ctrl_tb.sv
// self-checking testbench for the spread spectrum control
`timescale 1ns/100ps
module oscillator_spread_spectrum_ctrl_tb;
    import spread_pkg::*;
    logic mclk = 0;
    logic rst_n = 0;
    logic regWrite = 0;
    logic [DATA_W-1:0] regAddr = CONFIG_OFFSET;
    logic [DATA_W-1:0] regWdata = 8'h00;
    logic [DATA_W-1:0] regRdata;
    logic [OSC_W-1:0] oscCtrlBase = 8'h80;
    logic [OSC_W-1:0] oscCtrlOut;
    logic spreadActive;
    logic [7:0] d;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    oscillator_spread_spectrum_ctrl dut (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .oscCtrlBase(oscCtrlBase), .oscCtrlOut(oscCtrlOut),
        .spreadActive(spreadActive));
    initial forever #2.5 mclk = ~mclk;
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        regWrite = 1;
        regAddr = a;
        regWdata = v;
        @(negedge mclk);
        regWrite = 0;
        regAddr = CONFIG_OFFSET;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        regAddr = a;
        @(negedge mclk);
        v = regRdata;
    endtask : rd
    task automatic t_reset();
        rd(CONFIG_OFFSET, d);
        cmp8(d, 8'h00);
        cmp8(oscCtrlOut, oscCtrlBase);
        cmp8({7'h00, spreadActive}, 8'h00);
    endtask : t_reset
    task automatic t_fields();
        wr(CONFIG_OFFSET, 8'hff);
        rd(CONFIG_OFFSET, d);
        cmp8(d, 8'hfc);
        wr(8'h77, 8'h00);
        rd(CONFIG_OFFSET, d);
        cmp8(d, 8'hfc);
        rd(8'h75, d);
        cmp8(d, 8'h00);
        wr(CONFIG_OFFSET, 8'h00);
    endtask : t_fields
    task automatic t_sweep();
        int amp, hi, lo, diff;
        for (int c = 0; c < 4; c++) begin
            amp = 4 << c;
            hi = 0;
            lo = 0;
            wr(CONFIG_OFFSET, {4'h1, 2'(c), 2'b00});
            repeat (amp * 64 + 64) begin
                @(negedge mclk);
                diff = int'(oscCtrlOut) - 128;
                if (diff > hi) hi = diff;
                if (diff < lo) lo = diff;
            end
            cmp8(8'(hi), 8'(amp));
            cmp8(8'(-lo), 8'(amp));
            cmp8({7'h00, spreadActive}, 8'h01);
            wr(CONFIG_OFFSET, 8'h00);
        end
    endtask : t_sweep
    task automatic t_pace();
        int first, second;
        logic [7:0] prev;
        first = 0;
        second = 0;
        wr(CONFIG_OFFSET, 8'h20);
        prev = oscCtrlOut;
        for (int n = 1; n < 200 && second == 0; n++) begin
            @(negedge mclk);
            if (oscCtrlOut !== prev && first == 0) first = n;
            else if (oscCtrlOut !== prev) second = n;
            prev = oscCtrlOut;
        end
        cmp8(8'(second - first), 8'(2 * PACE_UNIT));
        wr(CONFIG_OFFSET, 8'h00);
    endtask : t_pace
    task automatic sat_run(input logic [7:0] base, input logic [7:0] expHi, input logic [7:0] expLo);
        logic [7:0] hi, lo;
        oscCtrlBase = base;
        hi = base;
        lo = base;
        wr(CONFIG_OFFSET, 8'h1c);
        repeat (32 * 64 + 64) begin
            @(negedge mclk);
            if (oscCtrlOut > hi) hi = oscCtrlOut;
            if (oscCtrlOut < lo) lo = oscCtrlOut;
        end
        cmp8(hi, expHi);
        cmp8(lo, expLo);
        wr(CONFIG_OFFSET, 8'h00);
    endtask : sat_run
    task automatic t_sat();
        sat_run(8'hf0, OSC_MAX, 8'hd0);
        sat_run(8'h10, 8'h30, 8'h00);
    endtask : t_sat
    task automatic t_off();
        wr(CONFIG_OFFSET, 8'h0c);
        oscCtrlBase = 8'h40;
        repeat (3) @(negedge mclk);
        cmp8({7'h00, spreadActive}, 8'h00);
        repeat (40) begin
            @(negedge mclk);
            cmp8(oscCtrlOut, 8'h40);
        end
    endtask : t_off
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1;
        t_reset();
        t_fields();
        t_sweep();
        t_pace();
        t_sat();
        t_off();
        close_out();
    end
endmodule : oscillator_spread_spectrum_ctrl_tb
